/* core/fzc_pkg.sv */
// Constants for the fan zone and coefficient configuration slice.
// Assumes a serial bus engine outside that presents byte register accesses.
package fzc_pkg;

    // ************************************************************
    // Register offsets and reset value
    // ************************************************************
    localparam logic [7:0] ADDR_COEF_OPT1  = 8'h79;
    localparam logic [7:0] ADDR_COEF_OPT2  = 8'h7a;
    localparam logic [7:0] ADDR_COEF_OPT3  = 8'h7b;
    localparam logic [7:0] ADDR_ZONE_SEL1  = 8'h7c;
    localparam logic [7:0] ADDR_ZONE_SEL2  = 8'h7d;
    localparam logic [7:0] ADDR_COEF_SEL1  = 8'h7e;
    localparam logic [7:0] ADDR_COEF_SEL2  = 8'h7f;
    localparam logic [7:0] REG_RESET       = 8'h00;
    localparam logic [7:0] RD_UNMAPPED     = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int GAIN_LO_LSB    = 6;  // Gain bits 1:0 in option 2
    localparam int OFFS_HI_LSB    = 0;  // Offset bits 8:3 in option 2
    localparam int OFFS_LO_LSB    = 5;  // Offset bits 2:0 in option 3
    localparam int SPINUP_LSB     = 0;  // Spin-up code in option 3
    localparam int ZONE_HI_LSB    = 4;  // First fan of a zone register
    localparam int ZONE_LO_LSB    = 0;  // Second fan of a zone register
    localparam int CSEL_LO_LSB    = 6;  // Channel select bits 1:0
    localparam int NUM_CHAN       = 10;
    localparam int NUM_FAN        = 4;

    // ************************************************************
    // Zone codes
    // ************************************************************
    localparam logic [3:0] ZONE_MAX_TEMP  = 4'h0;
    localparam logic [3:0] ZONE_LAST_CHAN = 4'ha;

    // ************************************************************
    // Spin-up timing
    // ************************************************************
    localparam int CLK_MHZ        = 100;
    localparam int MS_PER_US      = 1000;
    localparam int CYC_PER_MS     = CLK_MHZ * MS_PER_US;
    localparam int MS_CNT_W       = 12;
    localparam int CYC_CNT_W      = 17;
    localparam logic [2:0] SPINUP_NONE = 3'h0;
    localparam logic [MS_CNT_W-1:0] SPINUP_MS [8] = '{
        12'h000, 12'h064, 12'h0fa, 12'h190,
        12'h29b, 12'h3e8, 12'h7d0, 12'hfa0
    };  // 0, 100, 250, 400, 667, 1000, 2000, 4000 ms

    typedef enum logic [0:0] {SPIN_IDLE, SPIN_RUN} fzc_spin_type;

endpackage : fzc_pkg

/* core/fzc_spin_if.sv */
// Interface between the register slice and the spin-up timer.
// Assumes both ends share the one system clock.
interface fzc_spin_if;
    logic [2:0] code;    // Duration code from the register
    logic       start;   // One-cycle spin-up request
    logic       active;  // Spin-up running

    modport ctrl (output code, output start, input active);
    modport timer (input code, input start, output active);
endinterface : fzc_spin_if

/* core/fzc_spinup.sv */
// Automatic fan spin-up duration timer.
// Assumes start is a one-cycle pulse; a new start with a nonzero code restarts the timing.
module fzc_spinup #(
    parameter int CYC_PER_MS = fzc_pkg::CYC_PER_MS
) (
    input  wire logic     clk,  // System clock
    input  wire logic     rst,  // Async reset, active high
    fzc_spin_if.timer     sp    // Code, start and active
);

    fzc_pkg::fzc_spin_type               state_r, state_nxt;
    logic [fzc_pkg::MS_CNT_W-1:0]        ms_r, ms_nxt;
    logic [fzc_pkg::CYC_CNT_W-1:0]       cyc_r, cyc_nxt;
    logic                                ms_tick;

    // ************************************************************
    // Millisecond enable divider and countdown
    // ************************************************************
    assign ms_tick = (cyc_r == fzc_pkg::CYC_CNT_W'(CYC_PER_MS - 1));

    // Code 000 never starts a spin-up; 001..111 load the table
    always_comb begin
        state_nxt = state_r;
        ms_nxt    = ms_r;
        cyc_nxt   = ms_tick ? '0 : cyc_r + 1'b1;
        if (sp.start && sp.code != fzc_pkg::SPINUP_NONE) begin
            state_nxt = fzc_pkg::SPIN_RUN;
            ms_nxt    = fzc_pkg::SPINUP_MS[sp.code];
            cyc_nxt   = '0;
        end else begin
            case (state_r)
                fzc_pkg::SPIN_IDLE: begin
                    cyc_nxt = '0;  // Divider parked to save toggling
                end
                fzc_pkg::SPIN_RUN: begin
                    if (ms_tick) begin
                        ms_nxt = ms_r - 1'b1;
                        if (ms_r == fzc_pkg::MS_CNT_W'(1)) begin
                            state_nxt = fzc_pkg::SPIN_IDLE;
                        end
                    end
                end
                default: state_nxt = fzc_pkg::SPIN_IDLE;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= fzc_pkg::SPIN_IDLE;
            ms_r    <= '0;
            cyc_r   <= '0;
        end else begin
            state_r <= state_nxt;
            ms_r    <= ms_nxt;
            cyc_r   <= cyc_nxt;
        end
    end

    assign sp.active = (state_r == fzc_pkg::SPIN_RUN);

endmodule : fzc_spinup

/* core/fzc_top.sv */
// Fan zone selection and optional sensor coefficient register slice.
// Assumes a serial bus engine outside that presents single byte reads and
// writes on the register port, one access per cycle, synchronous to clk.
//
// Notes on behaviour
// - Option 2 bits 7:6 hold gain bits 1:0, read and write.
// - Option 2 bits 5:0 hold offset bits 8:3, read and write.
// - Option 3 bits 7:5 hold offset bits 2:0, forming a 9-bit offset.
// - Option 3 bits 2:0 pick spin-up time: none, 100ms up to 4s.
// - Zone select 1 bits 7:4 choose the zone for fan 1.
// - Zone select 1 bits 3:0 choose the zone for fan 2, same coding.
// - Zone code 0000 follows the maximum temperature value.
// - Zone codes 0001 to 1010 follow temperature channels 1 to 10.
// - All registers of this slice reset to 0x00.
// - Option 1 holds gain bits 9:2, making a 10-bit gain.
// - Per-channel select bit picks default or optional coefficients.
module fzc_top #(
    parameter int CYC_PER_MS = fzc_pkg::CYC_PER_MS  // Cycles per ms
) (
    input  wire logic        clk,                  // 100 MHz clock
    input  wire logic        rst,                  // Async reset
    input  wire logic [7:0]  reg_addr,             // Register address
    input  wire logic        reg_wr,               // Write strobe
    input  wire logic [7:0]  reg_wdata,            // Write data
    input  wire logic        reg_rd,               // Read strobe
    output logic      [7:0]  reg_rdata,            // Read data, held
    input  wire logic [7:0]  max_temp,             // Max of all sensors
    input  wire logic [79:0] chan_temp,            // Ten 8-bit channels
    input  wire logic        spinup_req,           // Fan start request
    output logic      [31:0] fan_zone_temp,        // Four 8-bit zone temps
    output logic      [9:0]  optional_gain_coef,   // Gain coefficient
    output logic      [8:0]  optional_offset_coef, // Offset coefficient
    output logic      [9:0]  coef_use_optional,    // Per-channel select
    output logic             spinup_active         // Spin-up in progress
);

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0]  opt1_r, opt1_nxt;
    logic [7:0]  opt2_r, opt2_nxt;
    logic [7:0]  opt3_r, opt3_nxt;
    logic [7:0]  zone1_r, zone1_nxt;
    logic [7:0]  zone2_r, zone2_nxt;
    logic [7:0]  csel1_r, csel1_nxt;
    logic [7:0]  csel2_r, csel2_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic [31:0] zone_temp_r, zone_temp_nxt;
    logic        spin_start_r, spin_start_nxt;
    logic        spin_act_r;
    logic [3:0]  fan_code [fzc_pkg::NUM_FAN];

    fzc_spin_if spin ();

    // Maps a zone code to its temperature; unused codes fall back to max
    function automatic logic [7:0] zone_pick(
        input logic [3:0]  code,
        input logic [7:0]  tmax,
        input logic [79:0] chans
    );
        logic [7:0] t;
        t = tmax;
        if (code != fzc_pkg::ZONE_MAX_TEMP
            && code <= fzc_pkg::ZONE_LAST_CHAN) begin
            t = chans[8*(int'(code)-1) +: 8];
        end
        return t;  // Codes above 1010 keep max: safest cooling
    endfunction : zone_pick

    // ************************************************************
    // Register writes
    // ************************************************************
    // Every register is plain read/write; fields need no masking
    always_comb begin
        opt1_nxt  = opt1_r;
        opt2_nxt  = opt2_r;
        opt3_nxt  = opt3_r;
        zone1_nxt = zone1_r;
        zone2_nxt = zone2_r;
        csel1_nxt = csel1_r;
        csel2_nxt = csel2_r;
        if (reg_wr) begin
            if (reg_addr == fzc_pkg::ADDR_COEF_OPT1) begin
                opt1_nxt = reg_wdata;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_OPT2) begin
                opt2_nxt = reg_wdata;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_OPT3) begin
                opt3_nxt = reg_wdata;
            end else if (reg_addr == fzc_pkg::ADDR_ZONE_SEL1) begin
                zone1_nxt = reg_wdata;
            end else if (reg_addr == fzc_pkg::ADDR_ZONE_SEL2) begin
                zone2_nxt = reg_wdata;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_SEL1) begin
                csel1_nxt = reg_wdata;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_SEL2) begin
                csel2_nxt = reg_wdata;
            end
        end
    end

    // ************************************************************
    // Register reads
    // ************************************************************
    // Read data holds between reads so a slow serial engine can shift it
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            if (reg_addr == fzc_pkg::ADDR_COEF_OPT1) begin
                rdata_nxt = opt1_r;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_OPT2) begin
                rdata_nxt = opt2_r;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_OPT3) begin
                rdata_nxt = opt3_r;
            end else if (reg_addr == fzc_pkg::ADDR_ZONE_SEL1) begin
                rdata_nxt = zone1_r;
            end else if (reg_addr == fzc_pkg::ADDR_ZONE_SEL2) begin
                rdata_nxt = zone2_r;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_SEL1) begin
                rdata_nxt = csel1_r;
            end else if (reg_addr == fzc_pkg::ADDR_COEF_SEL2) begin
                rdata_nxt = csel2_r;
            end else begin
                rdata_nxt = fzc_pkg::RD_UNMAPPED;
            end
        end
    end

    // ************************************************************
    // Zone temperature selection
    // ************************************************************
    assign fan_code[0] = zone1_r[fzc_pkg::ZONE_HI_LSB +: 4];
    assign fan_code[1] = zone1_r[fzc_pkg::ZONE_LO_LSB +: 4];
    assign fan_code[2] = zone2_r[fzc_pkg::ZONE_HI_LSB +: 4];
    assign fan_code[3] = zone2_r[fzc_pkg::ZONE_LO_LSB +: 4];

    // Same decode for every fan; one assign per byte keeps one driver each
    generate
        for (genvar f = 0; f < fzc_pkg::NUM_FAN; f++) begin : g_fan
            assign zone_temp_nxt[8*f +: 8] =
                zone_pick(fan_code[f], max_temp, chan_temp);
        end
    endgenerate

    // Start request passes through one flop to the timer
    always_comb begin
        spin_start_nxt = spinup_req;
    end

    assign spin.code  = opt3_r[fzc_pkg::SPINUP_LSB +: 3];
    assign spin.start = spin_start_r;

    fzc_spinup #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_spinup (
        .clk (clk),
        .rst (rst),
        .sp  (spin)
    );

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opt1_r       <= fzc_pkg::REG_RESET;
            opt2_r       <= fzc_pkg::REG_RESET;
            opt3_r       <= fzc_pkg::REG_RESET;
            zone1_r      <= fzc_pkg::REG_RESET;
            zone2_r      <= fzc_pkg::REG_RESET;
            csel1_r      <= fzc_pkg::REG_RESET;
            csel2_r      <= fzc_pkg::REG_RESET;
            rdata_r      <= fzc_pkg::REG_RESET;
            zone_temp_r  <= '0;
            spin_start_r <= 1'b0;
            spin_act_r   <= 1'b0;
        end else begin
            opt1_r       <= opt1_nxt;
            opt2_r       <= opt2_nxt;
            opt3_r       <= opt3_nxt;
            zone1_r      <= zone1_nxt;
            zone2_r      <= zone2_nxt;
            csel1_r      <= csel1_nxt;
            csel2_r      <= csel2_nxt;
            rdata_r      <= rdata_nxt;
            zone_temp_r  <= zone_temp_nxt;
            spin_start_r <= spin_start_nxt;
            spin_act_r   <= spin.active;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops
    // ************************************************************
    assign reg_rdata            = rdata_r;
    assign fan_zone_temp        = zone_temp_r;
    assign optional_gain_coef   =
        {opt1_r, opt2_r[fzc_pkg::GAIN_LO_LSB +: 2]};
    assign optional_offset_coef =
        {opt2_r[fzc_pkg::OFFS_HI_LSB +: 6],
         opt3_r[fzc_pkg::OFFS_LO_LSB +: 3]};
    assign coef_use_optional    =
        {csel1_r, csel2_r[fzc_pkg::CSEL_LO_LSB +: 2]};
    assign spinup_active        = spin_act_r;

endmodule : fzc_top

/* bench/fzc_host.sv */
// Host model standing in for the serial bus engine on the register port.
// Assumes the device takes a strobe at a rising edge; drives on falling.
module fzc_host (
    input  wire logic       clk,        // System clock
    output logic      [7:0] reg_addr,   // Register address
    output logic            reg_wr,     // Write strobe
    output logic      [7:0] reg_wdata,  // Write data
    output logic            reg_rd,     // Read strobe
    input  wire logic [7:0] reg_rdata   // Read data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle port at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // Released lines show the inverse, so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    // Data is taken at the falling edge, half a cycle after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : fzc_host

/* bench/fzc_chk_props.sv */
// Concurrent checks on the ports of the zone and coefficient slice.
// Assumes the one-cycle register port timing of fzc_top.
module fzc_chk #(
    parameter int CYC_PER_MS = 10  // Cycles per ms
) (
    input wire logic        clk,                  // Clock
    input wire logic        rst,                  // Async reset
    input wire logic [7:0]  reg_addr,             // Address
    input wire logic        reg_wr,               // Write strobe
    input wire logic [7:0]  reg_wdata,            // Write data
    input wire logic        reg_rd,               // Read strobe
    input wire logic [7:0]  reg_rdata,            // Read data
    input wire logic [7:0]  max_temp,             // Max temperature
    input wire logic [79:0] chan_temp,            // Channels
    input wire logic        spinup_req,           // Start request
    input wire logic [31:0] fan_zone_temp,        // Zone temps
    input wire logic [9:0]  optional_gain_coef,   // Gain
    input wire logic [8:0]  optional_offset_coef, // Offset
    input wire logic        spinup_active         // Spin-up running
);
    // ************************************************************
    // Shadow of zone and spin-up code, and an active-cycle counter
    // ************************************************************
    logic [7:0]  zsel_r;
    logic [2:0]  code_r;
    int          act_r;
    int          lim_w;
    logic [15:0] exp_w;
    function automatic logic [7:0] pick(logic [3:0] c);
        if (c == 4'h0 || c > 4'ha) return max_temp;
        return chan_temp[(c - 4'h1) * 8 +: 8];
    endfunction : pick
    assign exp_w = {pick(zsel_r[3:0]), pick(zsel_r[7:4])};
    assign lim_w = int'(fzc_pkg::SPINUP_MS[code_r]) * CYC_PER_MS;
    // Counter restarts on an accepted request, as the timer does
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zsel_r <= 8'h00;
            code_r <= 3'h0;
            act_r <= 0;
        end else begin
            if (reg_wr && reg_addr == 8'h7c) zsel_r <= reg_wdata;
            if (reg_wr && reg_addr == 8'h7b) code_r <= reg_wdata[2:0];
            if (spinup_req && code_r != 3'h0) act_r <= 0;
            else if (spinup_active) act_r <= act_r + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_gain_lo_wr: assert property (reg_wr && reg_addr == 8'h7a |=>
        optional_gain_coef[1:0] == $past(reg_wdata[7:6]))
        else $error("gain low bits not written");
    a_offs_hi_wr: assert property (reg_wr && reg_addr == 8'h7a |=>
        optional_offset_coef[8:3] == $past(reg_wdata[5:0]))
        else $error("offset high bits not written");
    a_offs_lo_wr: assert property (reg_wr && reg_addr == 8'h7b |=>
        optional_offset_coef[2:0] == $past(reg_wdata[7:5]))
        else $error("offset low bits not written");
    a_gain_hi_wr: assert property (reg_wr && reg_addr == 8'h79 |=>
        optional_gain_coef[9:2] == $past(reg_wdata))
        else $error("gain high bits not written");
    a_rd_old_opt2: assert property (reg_rd && !reg_wr
        && reg_addr == 8'h7a |=> reg_rdata ==
        {optional_gain_coef[1:0], optional_offset_coef[8:3]})
        else $error("option 2 read wrong");
    a_spin_start: assert property (spinup_req && code_r != 3'h0
        && !spinup_active |-> ##3 spinup_active)
        else $error("spin-up did not start");
    a_spin_cause: assert property ($rose(spinup_active) |->
        $past(spinup_req, 3) && $past(code_r, 3) != 3'h0)
        else $error("spin-up without request");
    a_spin_len: assert property ($fell(spinup_active) |->
        act_r >= lim_w - 2 && act_r <= lim_w + 2)
        else $error("spin-up length wrong");
    a_first_fan_zone_sel: assert property (!$past(rst) |->
        fan_zone_temp[7:0] == $past(exp_w[7:0]))
        else $error("fan 1 zone temperature wrong");
    a_second_fan_zone_sel: assert property (!$past(rst) |->
        fan_zone_temp[15:8] == $past(exp_w[15:8]))
        else $error("fan 2 zone temperature wrong");
endmodule : fzc_chk
bind fzc_top fzc_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .max_temp(max_temp), .chan_temp(chan_temp), .spinup_req(spinup_req),
    .fan_zone_temp(fan_zone_temp), .optional_gain_coef(optional_gain_coef),
    .optional_offset_coef(optional_offset_coef),
    .spinup_active(spinup_active));

/* bench/fzc_top_test.sv */
// Self-checking bench for the zone and coefficient register slice.
// Assumes fzc_top with a shortened ms count, driven by the host model.
module fzc_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CPM = 10;  // Short ms keeps spin-up runs brief
    logic        clk, rst, reg_wr, reg_rd, spinup_req, spinup_active;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, max_temp, rv;
    logic [79:0] chan_temp;
    logic [31:0] fan_zone_temp;
    logic [9:0]  gain, csel;
    logic [8:0]  offs;
    int          failures, cmp_count, cyc;
    fzc_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    fzc_top #(.CYC_PER_MS(CPM)) uut (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .max_temp(max_temp),
        .chan_temp(chan_temp), .spinup_req(spinup_req),
        .fan_zone_temp(fan_zone_temp), .optional_gain_coef(gain),
        .optional_offset_coef(offs), .coef_use_optional(csel),
        .spinup_active(spinup_active));
    // ************************************************************
    // Clock, hang guard, compare and closing report
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_sim;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        for (int a = 8'h79; a <= 8'h7d; a++) begin
            host.rd(8'(a), rv);
            chk("reset byte", 8'h00, rv);
        end
        chk("reset outs", 32'h0, {gain, offs, csel, spinup_active});
        chk("reset zones", {4{max_temp}}, fan_zone_temp);
        $display("test reset done");
    endtask : t_reset
    // Fields straddle bytes, so check both the bytes and the joined values
    task automatic t_coef;
        host.wr(8'h79, 8'ha5);
        host.wr(8'h7a, 8'hc3);
        host.wr(8'h7b, 8'hb4);
        host.rd(8'h7a, rv);
        chk("opt2", 8'hc3, rv);
        host.rd(8'h7b, rv);
        chk("opt3", 8'hb4, rv);
        host.rd(8'h79, rv);
        chk("opt1", 8'ha5, rv);
        chk("gain", {8'ha5, 2'h3}, gain);
        chk("offset", {6'h03, 3'h5}, offs);
        host.wr(8'h7e, 8'h96);
        host.wr(8'h7f, 8'h45);
        chk("coef sel", 10'h259, csel);
        host.rd(8'h7f, rv);
        chk("coef sel 2", 8'h45, rv);
        host.wr(8'h80, 8'h77);
        host.rd(8'h80, rv);
        chk("unmapped", 8'h00, rv);
        $display("test coef done");
    endtask : t_coef
    function automatic logic [7:0] zt(input logic [3:0] c);
        if (c == 4'h0 || c > 4'ha) return max_temp;
        return chan_temp[(c - 4'h1) * 8 +: 8];
    endfunction : zt
    // All sixteen codes on fan 1, the mirror order on fan 2
    task automatic t_zone;
        for (int c = 0; c < 16; c++) begin
            host.wr(8'h7c, {4'(c), 4'(15 - c)});
            repeat (2) @(negedge clk);
            chk("fan1", zt(4'(c)), fan_zone_temp[7:0]);
            chk("fan2", zt(4'(15-c)), fan_zone_temp[15:8]);
        end
        host.wr(8'h7d, 8'h3c);
        repeat (2) @(negedge clk);
        chk("fan34", {zt(4'hc), zt(4'h3)}, fan_zone_temp[31:16]);
        host.rd(8'h7c, rv);
        chk("zone sel 1", 8'hf0, rv);
        $display("test zone done");
    endtask : t_zone
    task automatic pulse;
        @(negedge clk);
        spinup_req = 1'b1;
        @(negedge clk);
        spinup_req = 1'b0;
    endtask : pulse
    task automatic t_spin;
        int n;
        int e;
        host.wr(8'h7b, 8'h00);
        pulse;
        repeat (6) @(negedge clk);
        chk("no spinup", 1'b0, spinup_active);
        for (int c = 1; c < 4; c++) begin
            host.wr(8'h7b, 8'(c));
            e = int'(fzc_pkg::SPINUP_MS[c]) * CPM;
            pulse;
            repeat (2) @(negedge clk);
            chk("spin start", 1'b1, spinup_active);
            n = 0;
            while (spinup_active === 1'b1 && n < 50000) begin
                n++;
                @(negedge clk);
            end
            chk("spin len", 1'b1, n >= e - 1 && n <= e + 1);
        end
        $display("test spin done");
    endtask : t_spin
    // Long codes only start and restart; a mid-run reset then ends them
    task automatic t_rst_mid;
        for (int c = 4; c < 8; c++) begin
            host.wr(8'h7b, 8'(c));
            pulse;
            repeat (2) @(negedge clk);
            chk("spin restart", 1'b1, spinup_active);
        end
        host.wr(8'h7c, 8'h5a);
        rst = 1'b1;
        @(negedge clk);
        chk("outs in reset", 32'h0, {gain, offs, csel, spinup_active});
        chk("zones in reset", 32'h0, fan_zone_temp);
        @(negedge clk);
        rst = 1'b0;
        t_reset;
        $display("test mid reset done");
    endtask : t_rst_mid
    // Main sequence
    initial begin
        rst = 1'b1;
        spinup_req = 1'b0;
        max_temp = 8'h5a;
        for (int n = 0; n < 10; n++) begin
            chan_temp[n * 8 +: 8] = 8'(8'h11 + n);
        end
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_coef;
        t_zone;
        t_spin;
        t_rst_mid;
        end_sim;
    end
endmodule : fzc_top_test
